// ===== logic/iqc_map.svh
/*
 Register indices, field positions, reset values and pipeline constants of the
 I/Q correction datapath.
 Assumes the includer addresses registers as byte address = 4 * index.
*/
`ifndef IQC_MAP_SVH
`define IQC_MAP_SVH

// Register indices, byte address is four times the index
`define IQC_IDX_PAGE 10'h008
`define IQC_IDX_TRIM 10'h014
`define IQC_IDX_SYNC 10'h050
`define IQC_IDX_KEY_I_LO 10'h051
`define IQC_IDX_KEY_I_HI 10'h052
`define IQC_IDX_KEY_Q_LO 10'h053
`define IQC_IDX_KEY_Q_HI 10'h054
`define IQC_IDX_CTRL 10'h111
`define IQC_IDX_SKEW_LO 10'h11C
`define IQC_IDX_SKEW_HI 10'h11D
`define IQC_IDX_BIAS_CTRL 10'h135
`define IQC_IDX_BIAS_I_LO 10'h136
`define IQC_IDX_BIAS_I_HI 10'h137
`define IQC_IDX_BIAS_Q_LO 10'h138
`define IQC_IDX_BIAS_Q_HI 10'h139
`define IQC_IDX_FRAC_I 10'h13A
`define IQC_IDX_FRAC_Q 10'h13B
`define IQC_IDX_GAIN_I_LO 10'h13C
`define IQC_IDX_GAIN_I_HI 10'h13D
`define IQC_IDX_GAIN_Q_LO 10'h13E
`define IQC_IDX_GAIN_Q_HI 10'h13F

// Field positions
`define IQC_CTRL_EXCHANGE 0
`define IQC_CTRL_SKEW_ON 4
`define IQC_CTRL_GAIN_ON 5
`define IQC_SYNC_ARM 7
`define IQC_SYNC_HIT 5
`define IQC_SYNC_OK 4
`define IQC_SYNC_BAD 3

// Reset values
`define IQC_RST_CTRL 8'h20
`define IQC_RST_GAIN 12'hAEA
`define IQC_RST_PAGE 2'h3
`define IQC_RST_TRIM 8'h08

// Datapath constants
`define IQC_GAIN_SHIFT 11
`define IQC_SKEW_COEF 11'h3E8
`define IQC_SKEW_SHIFT 25
`define IQC_SEL_EDGE 2'h1
`define IQC_SEL_KEY 2'h2
`define IQC_RESP_OKAY 2'h0
`define IQC_RESP_SLVERR 2'h2

`endif

// ===== logic/iqc_pkg.sv
/*
 Types of the I/Q correction datapath: sample carriers, per-dual settings,
 per-dual pipeline and the whole module state.
 Assumes iqc_map.svh for the numeric constants.
*/
package iqc_pkg;

   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } iqc_iq_t;

   typedef iqc_iq_t [1:0] iqc_lanes_t;

   typedef struct packed {
      logic [7:0] trim;
      logic [7:0] ctrl;
      logic [12:0] skew_word;
      logic bias_corr_on;
      logic [15:0] bias_whole_i;
      logic [15:0] bias_whole_q;
      logic [4:0] bias_fraction_i;
      logic [4:0] bias_fraction_q;
      logic [11:0] gain_word_i;
      logic [11:0] gain_word_q;
      logic [1:0] osc_sync_select;
      logic osc_sync_arm;
      logic osc_key_hit;
      logic osc_sync_ok;
      logic osc_sync_bad;
      logic [15:0] osc_key_i;
      logic [15:0] osc_key_q;
   } iqc_cfg_t;

   typedef struct packed {
      iqc_iq_t gained;
      logic [3:0] resid_i;
      logic [3:0] resid_q;
      logic [8:0][15:0] tap_i;
      logic [8:0][15:0] tap_q;
      iqc_iq_t out;
      logic align_pulse;
   } iqc_pipe_t;

   typedef struct packed {
      iqc_cfg_t [1:0] cfg;
      iqc_pipe_t [1:0] pipe;
      logic [1:0] page;
      logic sysref_d;
      logic aw_got;
      logic [9:0] aw_idx;
      logic w_got;
      logic [7:0] w_byte;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } iqc_state_t;

endpackage : iqc_pkg

// ===== logic/iqc_datapath.sv
/*
 I/Q correction stage for two DAC duals: gain, phase skew, dc offset with
 sub-LSB resolution, group delay trim, lane exchange and oscillator alignment
 control, configured over an AXI4-Lite slave.
 Assumes one clock at the DAC sample rate, samples valid every cycle, and an
 AXI4-Lite master with at most one write and one read outstanding.
*/
// Overview of operation
// - Gain applied only while gain_on set
// - Gain is 12-bit word over 2048
// - Reset: gain on, both words 0xAEA
// - Separate I/Q gain words, low/high registers
// - 13-bit skew word alters I/Q angle
// - Skew applied only while skew_corr_on set
// - Offset: whole LSBs plus sixteenths
// - Offset applied only while bias_corr_on set
// - I offset to I, Q offset to Q
// - Per-dual delay trim in half-cycle steps
// - Trim code from its own register
// - lane_exchange swaps I and Q outputs
// - Exchange is the last datapath stage
// - Per-dual settings selected by paging
// - Edge mode aligns on sysref rising edge
// - Key mode aligns on matching sample
// - Two-bit select: 01 edge, 10 key
// - Compare samples to 16-bit key words
// - Arm bit, then hit/ok/bad status
`timescale 1ns/1ps
`include "iqc_map.svh"

module iqc_datapath (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire iqc_pkg::iqc_lanes_t sample_in,
   input wire logic sysref,
   output iqc_pkg::iqc_lanes_t dac_out,
   output logic [1:0] osc_align_pulse
);

   // ----------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------

   function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
      if (v > 40'sh00_0000_7FFF) begin
         sat16 = 16'sh7FFF;
      end else if (v < -40'sh00_0000_8000) begin
         sat16 = -16'sh8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction : sat16

   function automatic logic signed [15:0] apply_gain(input logic signed [15:0] x,
                                                     input logic [11:0] g,
                                                     input logic on);
      logic signed [39:0] p;
      p = 40'(x * $signed({1'b0, g}));
      apply_gain = on ? sat16(p >>> `IQC_GAIN_SHIFT) : x;
   endfunction : apply_gain

   // Small-angle rotation: each lane takes half the skew from the other lane
   function automatic logic signed [39:0] skew_term(input logic signed [15:0] x,
                                                    input logic [12:0] s);
      logic signed [39:0] p;
      p = 40'(x * $signed(s) * $signed({1'b0, `IQC_SKEW_COEF}));
      skew_term = p >>> `IQC_SKEW_SHIFT;
   endfunction : skew_term

   // Offset in sixteenths with error feedback, so the fraction shows as a mean
   function automatic logic [19:0] add_bias(input logic signed [39:0] x,
                                            input logic [15:0] whole,
                                            input logic [4:0] frac,
                                            input logic [3:0] resid,
                                            input logic on);
      logic signed [39:0] acc;
      logic signed [15:0] s;
      acc = x <<< 4;
      if (on) begin
         acc = acc + ($signed({{24{whole[15]}}, whole}) <<< 4)
               + $signed({{35{frac[4]}}, frac}) + $signed({36'h0_0000_0000, resid});
      end
      s = sat16(acc >>> 4);
      add_bias = {s, on ? acc[3:0] : 4'h0};
   endfunction : add_bias

   function automatic logic [15:0] pick_tap(input logic [8:0][15:0] taps,
                                            input logic [3:0] code);
      logic signed [16:0] sum;
      logic [3:0] n;
      n = {1'b0, code[3:1]};
      sum = $signed({taps[n][15], taps[n]}) + $signed({taps[n + 4'h1][15], taps[n + 4'h1]});
      pick_tap = code[0] ? sum[16:1] : taps[n];
   endfunction : pick_tap

   function automatic logic [8:0] read_reg(input iqc_pkg::iqc_cfg_t c,
                                           input logic [1:0] page,
                                           input logic [9:0] idx);
      logic [7:0] d;
      logic ok;
      d = 8'h00;
      ok = 1'b1;
      unique case (idx)
         `IQC_IDX_PAGE: d = {6'h00, page};
         `IQC_IDX_TRIM: d = c.trim;
         `IQC_IDX_SYNC: d = {c.osc_sync_arm, 1'b0, c.osc_key_hit, c.osc_sync_ok,
                             c.osc_sync_bad, 1'b0, c.osc_sync_select};
         `IQC_IDX_KEY_I_LO: d = c.osc_key_i[7:0];
         `IQC_IDX_KEY_I_HI: d = c.osc_key_i[15:8];
         `IQC_IDX_KEY_Q_LO: d = c.osc_key_q[7:0];
         `IQC_IDX_KEY_Q_HI: d = c.osc_key_q[15:8];
         `IQC_IDX_CTRL: d = c.ctrl;
         `IQC_IDX_SKEW_LO: d = c.skew_word[7:0];
         `IQC_IDX_SKEW_HI: d = {3'h0, c.skew_word[12:8]};
         `IQC_IDX_BIAS_CTRL: d = {7'h00, c.bias_corr_on};
         `IQC_IDX_BIAS_I_LO: d = c.bias_whole_i[7:0];
         `IQC_IDX_BIAS_I_HI: d = c.bias_whole_i[15:8];
         `IQC_IDX_BIAS_Q_LO: d = c.bias_whole_q[7:0];
         `IQC_IDX_BIAS_Q_HI: d = c.bias_whole_q[15:8];
         `IQC_IDX_FRAC_I: d = {3'h0, c.bias_fraction_i};
         `IQC_IDX_FRAC_Q: d = {3'h0, c.bias_fraction_q};
         `IQC_IDX_GAIN_I_LO: d = c.gain_word_i[7:0];
         `IQC_IDX_GAIN_I_HI: d = {4'h0, c.gain_word_i[11:8]};
         `IQC_IDX_GAIN_Q_LO: d = c.gain_word_q[7:0];
         `IQC_IDX_GAIN_Q_HI: d = {4'h0, c.gain_word_q[11:8]};
         default: ok = 1'b0;
      endcase
      read_reg = {ok, d};
   endfunction : read_reg

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------

   iqc_pkg::iqc_state_t st;
   iqc_pkg::iqc_state_t next_st;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------

   always_comb begin
      logic [8:0] rd;
      logic mapped;
      logic do_write;
      logic edge_seen;
      logic signed [39:0] ci;
      logic signed [39:0] cq;
      logic [19:0] bi;
      logic [19:0] bq;
      logic [15:0] li;
      logic [15:0] lq;
      iqc_pkg::iqc_cfg_t c;
      rd = 9'h000;
      mapped = 1'b0;
      do_write = 1'b0;
      edge_seen = 1'b0;
      ci = 40'sh00_0000_0000;
      cq = 40'sh00_0000_0000;
      bi = 20'h0_0000;
      bq = 20'h0_0000;
      li = 16'h0000;
      lq = 16'h0000;
      c = st.cfg[0];
      next_st = st;

      // AXI write: address and data taken in either order, answer after both
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_got = 1'b1;
         next_st.aw_idx = s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_got = 1'b1;
         next_st.w_byte = s_axi_wdata[7:0];
         next_st.w_lane0 = s_axi_wstrb[0];
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
         do_write = 1'b1;
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         mapped = read_reg(st.cfg[0], st.page, st.aw_idx) >> 8 != 9'h000;
         next_st.bresp = mapped ? `IQC_RESP_OKAY : `IQC_RESP_SLVERR;
      end
      if (do_write && st.w_lane0 && st.aw_idx == `IQC_IDX_PAGE) begin
         next_st.page = st.w_byte[1:0];
      end

      edge_seen = sysref && !st.sysref_d;
      next_st.sysref_d = sysref;

      for (int d = 0; d < 2; d++) begin
         c = st.cfg[d];
         if (do_write && st.w_lane0 && st.page[d]) begin
            unique case (st.aw_idx)
               `IQC_IDX_TRIM: c.trim = st.w_byte;
               `IQC_IDX_SYNC: begin
                  c.osc_sync_select = st.w_byte[1:0];
                  c.osc_sync_arm = st.w_byte[`IQC_SYNC_ARM];
                  if (st.w_byte[`IQC_SYNC_ARM]) begin
                     c.osc_key_hit = 1'b0;
                     c.osc_sync_ok = 1'b0;
                     c.osc_sync_bad = 1'b0;
                  end
               end
               `IQC_IDX_KEY_I_LO: c.osc_key_i[7:0] = st.w_byte;
               `IQC_IDX_KEY_I_HI: c.osc_key_i[15:8] = st.w_byte;
               `IQC_IDX_KEY_Q_LO: c.osc_key_q[7:0] = st.w_byte;
               `IQC_IDX_KEY_Q_HI: c.osc_key_q[15:8] = st.w_byte;
               `IQC_IDX_CTRL: c.ctrl = st.w_byte;
               `IQC_IDX_SKEW_LO: c.skew_word[7:0] = st.w_byte;
               `IQC_IDX_SKEW_HI: c.skew_word[12:8] = st.w_byte[4:0];
               `IQC_IDX_BIAS_CTRL: c.bias_corr_on = st.w_byte[0];
               `IQC_IDX_BIAS_I_LO: c.bias_whole_i[7:0] = st.w_byte;
               `IQC_IDX_BIAS_I_HI: c.bias_whole_i[15:8] = st.w_byte;
               `IQC_IDX_BIAS_Q_LO: c.bias_whole_q[7:0] = st.w_byte;
               `IQC_IDX_BIAS_Q_HI: c.bias_whole_q[15:8] = st.w_byte;
               `IQC_IDX_FRAC_I: c.bias_fraction_i = st.w_byte[4:0];
               `IQC_IDX_FRAC_Q: c.bias_fraction_q = st.w_byte[4:0];
               `IQC_IDX_GAIN_I_LO: c.gain_word_i[7:0] = st.w_byte;
               `IQC_IDX_GAIN_I_HI: c.gain_word_i[11:8] = st.w_byte[3:0];
               `IQC_IDX_GAIN_Q_LO: c.gain_word_q[7:0] = st.w_byte;
               `IQC_IDX_GAIN_Q_HI: c.gain_word_q[11:8] = st.w_byte[3:0];
               default: ;
            endcase
         end

         // Alignment events follow the write, so a set is never lost to it
         next_st.pipe[d].align_pulse = 1'b0;
         if (st.cfg[d].osc_sync_arm) begin
            unique case (st.cfg[d].osc_sync_select)
               `IQC_SEL_EDGE: begin
                  if (edge_seen) begin
                     c.osc_sync_ok = 1'b1;
                     c.osc_sync_arm = 1'b0;
                     next_st.pipe[d].align_pulse = 1'b1;
                  end
               end
               `IQC_SEL_KEY: begin
                  if (sample_in[d].i == st.cfg[d].osc_key_i &&
                      sample_in[d].q == st.cfg[d].osc_key_q) begin
                     c.osc_key_hit = 1'b1;
                     c.osc_sync_ok = 1'b1;
                     c.osc_sync_arm = 1'b0;
                     next_st.pipe[d].align_pulse = 1'b1;
                  end
               end
               default: begin
                  c.osc_sync_bad = 1'b1;
                  c.osc_sync_arm = 1'b0;
               end
            endcase
         end
         next_st.cfg[d] = c;

         // Stage 1: gain
         // Gated by gain_on
         next_st.pipe[d].gained.i = apply_gain(sample_in[d].i, st.cfg[d].gain_word_i,
                                               st.cfg[d].ctrl[`IQC_CTRL_GAIN_ON]);
         next_st.pipe[d].gained.q = apply_gain(sample_in[d].q, st.cfg[d].gain_word_q,
                                               st.cfg[d].ctrl[`IQC_CTRL_GAIN_ON]);

         // Stage 2: skew then offset, saturated into tap 0
         ci = 40'(st.pipe[d].gained.i);
         cq = 40'(st.pipe[d].gained.q);
         if (st.cfg[d].ctrl[`IQC_CTRL_SKEW_ON]) begin
            ci = ci + skew_term(st.pipe[d].gained.q, st.cfg[d].skew_word);
            cq = cq + skew_term(st.pipe[d].gained.i, st.cfg[d].skew_word);
         end
         bi = add_bias(ci, st.cfg[d].bias_whole_i, st.cfg[d].bias_fraction_i,
                       st.pipe[d].resid_i, st.cfg[d].bias_corr_on);
         bq = add_bias(cq, st.cfg[d].bias_whole_q, st.cfg[d].bias_fraction_q,
                       st.pipe[d].resid_q, st.cfg[d].bias_corr_on);
         next_st.pipe[d].resid_i = bi[3:0];
         next_st.pipe[d].resid_q = bq[3:0];
         next_st.pipe[d].tap_i = {st.pipe[d].tap_i[7:0], bi[19:4]};
         next_st.pipe[d].tap_q = {st.pipe[d].tap_q[7:0], bq[19:4]};

         li = pick_tap(st.pipe[d].tap_i, st.cfg[d].trim[3:0]);
         lq = pick_tap(st.pipe[d].tap_q, st.cfg[d].trim[3:0]);

         if (st.cfg[d].ctrl[`IQC_CTRL_EXCHANGE]) begin
            next_st.pipe[d].out.i = lq;
            next_st.pipe[d].out.q = li;
         end else begin
            next_st.pipe[d].out.i = li;
            next_st.pipe[d].out.q = lq;
         end
      end

      // AXI read: one outstanding, answered the cycle after address
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st.arready) begin
         // Reads show the lowest paged dual, or dual 1 when page is 0
         rd = read_reg(st.page[0] ? st.cfg[0] : st.cfg[1], st.page, s_axi_araddr[11:2]);
         next_st.rvalid = 1'b1;
         next_st.rdata = {24'h00_0000, rd[8] ? rd[7:0] : 8'h00};
         next_st.rresp = rd[8] ? `IQC_RESP_OKAY : `IQC_RESP_SLVERR;
      end
      next_st.awready = !next_st.aw_got && !next_st.bvalid;
      next_st.wready = !next_st.w_got && !next_st.bvalid;
      next_st.arready = !next_st.rvalid;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         for (int d = 0; d < 2; d++) begin
            st.cfg[d].ctrl <= `IQC_RST_CTRL;
            st.cfg[d].gain_word_i <= `IQC_RST_GAIN;
            st.cfg[d].gain_word_q <= `IQC_RST_GAIN;
            st.cfg[d].trim <= `IQC_RST_TRIM;
         end
         st.page <= `IQC_RST_PAGE;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flops
   // ----------------------------------------------------------------

   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign dac_out[0] = st.pipe[0].out;
   assign dac_out[1] = st.pipe[1].out;
   assign osc_align_pulse = {st.pipe[1].align_pulse, st.pipe[0].align_pulse};

endmodule : iqc_datapath

// ===== testbench/iqc_datapath_asserts.sv
/*
 Checker on the datapath ports: bus answers, alignment pulse, reset.
 Assumes it is bound to iqc_datapath and sees its ports only.
*/
`timescale 1ns/1ps
module iqc_datapath_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rready,
   input wire iqc_pkg::iqc_lanes_t dac_out,
   input wire logic [1:0] osc_align_pulse
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_write_answer: assert property (both_taken |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_rdata_byte: assert property (s_axi_rvalid |-> (s_axi_rdata >> 8) == 32'h0000_0000)
      else $error("read data upper bits set");
   chk_pulse_single: assert property ((osc_align_pulse & $past(osc_align_pulse)) == 2'h0)
      else $error("alignment pulse too long");
   chk_reset_quiet: assert property (disable iff (1'h0) !aresetn |=>
      dac_out == 64'h0000_0000_0000_0000 && osc_align_pulse == 2'h0 && !s_axi_bvalid)
      else $error("outputs not cleared by reset");
endmodule : iqc_datapath_asserts

// ===== testbench/iqc_sample_source.sv
/*
 Upstream sample source: registers requested samples and the sysref level.
 Assumes the bench changes its requests right after a rising edge.
*/
`timescale 1ns/1ps
module iqc_sample_source (
   input wire logic aclk,
   input wire iqc_pkg::iqc_lanes_t req,
   input wire logic sysref_req,
   output iqc_pkg::iqc_lanes_t sample_in,
   output logic sysref
);
   iqc_pkg::iqc_lanes_t held = 64'h0000_0000_0000_0000;
   logic edge_held = 1'h0;
   always @(posedge aclk) begin
      held <= req;
      edge_held <= sysref_req;
   end
   assign sample_in = held;
   assign sysref = edge_held;
endmodule : iqc_sample_source

// ===== testbench/iqc_datapath_bench.sv
/*
 Self-checking bench of the I/Q correction datapath over AXI4-Lite.
 Assumes the map header and package of the design are compiled first.
*/
`timescale 1ns/1ps
`include "iqc_map.svh"
module iqc_datapath_bench;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0;
   logic [2:0] s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic sysref_req = 1'h0;
   iqc_pkg::iqc_lanes_t req = 64'h0000_0000_0000_0000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sysref;
   logic [1:0] s_axi_bresp, s_axi_rresp, osc_align_pulse, bresp_seen, rresp_seen;
   logic [31:0] s_axi_rdata;
   iqc_pkg::iqc_lanes_t sample_in, dac_out;
   int miscompares = 0;
   int comparisons = 0;
   int pulses = 0;
   always #25 aclk = ~aclk;
   always @(posedge aclk) if (osc_align_pulse === 2'h3) pulses++;
   iqc_datapath DUT (.*);
   iqc_sample_source SRC (.aclk, .req, .sysref_req, .sample_in, .sysref);

   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic guard(input int n);
      if (n >= 40) begin
         miscompares++;
         finish_test();
      end
   endtask : guard
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_val
   task automatic chk_smp(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_smp
   function automatic logic [15:0] sat(input int v);
      if (v > 32767) return 16'h7FFF;
      if (v < -32768) return 16'h8000;
      return v[15:0];
   endfunction : sat

   // ------------------------------------------------------------
   // Bus cycles: both channels offered together, each released when taken
   // ------------------------------------------------------------
   task automatic wr(input logic [9:0] ix, input logic [7:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= {ix, 2'h0};
      s_axi_wdata <= {24'h0000_00, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid && n < 40);
      guard(n);
      bresp_seen = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [9:0] ix, output logic [31:0] d);
      int n;
      n = 0;
      s_axi_araddr <= {ix, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid && n < 40);
      guard(n);
      d = s_axi_rdata;
      rresp_seen = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask : rd
   task automatic wg(input int g, input int h);
      wr(`IQC_IDX_GAIN_I_LO, g[7:0]);
      wr(`IQC_IDX_GAIN_I_HI, {4'h0, g[11:8]});
      wr(`IQC_IDX_GAIN_Q_LO, h[7:0]);
      wr(`IQC_IDX_GAIN_Q_HI, {4'h0, h[11:8]});
   endtask : wg
   // Constant stream: 20 cycles cover the longest trim latency
   task automatic drive(input logic [15:0] i, input logic [15:0] q);
      req <= {i, q, i, q};
      repeat (20) @(posedge aclk);
   endtask : drive
   task automatic lat(input logic [7:0] code, output int n);
      wr(`IQC_IDX_TRIM, code);
      drive(16'h0000, 16'h0000);
      req <= {4{16'h5A5A}};
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (dac_out[0].i !== 16'h5A5A && n < 40);
      guard(n);
   endtask : lat

   initial begin
      logic [31:0] d;
      logic [15:0] e, f;
      int k, g, h, x, y, b, c, n0, n1;
      void'($urandom(32'he58827a6));
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(`IQC_IDX_CTRL, d);
      chk_val(d, 32'h0000_0020);
      for (k = 0; k < 4; k++) begin
         rd(`IQC_IDX_GAIN_I_LO + k, d);
         chk_val(d, k[0] ? 32'h0000_000A : 32'h0000_00EA);
      end
      rd(10'h3FF, d);
      chk_val({d[29:0], rresp_seen}, {30'h0000_0000, `IQC_RESP_SLVERR});
      wr(10'h3FE, 8'h55);
      chk_val(bresp_seen, `IQC_RESP_SLVERR);
      $display("reset test done");
      wr(`IQC_IDX_TRIM, 8'h00);
      wr(`IQC_IDX_PAGE, 8'h02);
      wg(2048, 2048);
      wr(`IQC_IDX_PAGE, 8'h01);
      for (k = 0; k < 6; k++) begin
         // Advised interpolation words as a corner
         g = (k == 0) ? 4095 : (k == 1) ? 32'h0000_0BB3 : $urandom_range(4095);
         h = (k == 0) ? 0 : (k == 1) ? 32'h0000_0BF8 : $urandom_range(4095);
         x = (k == 0) ? 30720 : (int'($urandom_range(30)) - 15) * 2048;
         wg(g, h);
         drive(x[15:0], x[15:0]);
         chk_smp(dac_out[0].i, sat(x * g / 2048));
         chk_smp(dac_out[0].q, sat(x * h / 2048));
         chk_smp(dac_out[1].i, x[15:0]);
      end
      $display("gain test done");
      wr(`IQC_IDX_PAGE, 8'h03);
      for (k = 0; k < 4; k++) begin
         x = (k == 1) ? 32752 : $signed(16'($urandom));
         y = $signed(16'($urandom));
         b = (k == 1) ? 256 : $signed(16'($urandom));
         c = $signed(16'($urandom));
         // No blanking here, so gain may go off
         wr(`IQC_IDX_CTRL, {7'h00, k[1]});
         wr(`IQC_IDX_BIAS_CTRL, {7'h00, k[0]});
         wr(`IQC_IDX_BIAS_I_LO, b[7:0]);
         wr(`IQC_IDX_BIAS_I_HI, b[15:8]);
         wr(`IQC_IDX_BIAS_Q_LO, c[7:0]);
         wr(`IQC_IDX_BIAS_Q_HI, c[15:8]);
         drive(x[15:0], y[15:0]);
         e = sat(x + (k[0] ? b : 0));
         f = sat(y + (k[0] ? c : 0));
         chk_smp(dac_out[1].i, k[1] ? f : e);
         chk_smp(dac_out[1].q, k[1] ? e : f);
      end
      wr(`IQC_IDX_BIAS_CTRL, 8'h00);
      wr(`IQC_IDX_SKEW_HI, 8'h08);
      wr(`IQC_IDX_CTRL, 8'h10);
      drive(16'h4000, 16'h0000);
      chk_smp(dac_out[1].q, {5'h00, `IQC_SKEW_COEF});
      wr(`IQC_IDX_CTRL, 8'h00);
      $display("bias test done");
      lat(8'h00, n0);
      lat(8'h06, n1);
      chk_val(n1 - n0, 3);
      $display("delay test done");
      k = $urandom;
      for (g = 0; g < 4; g++) wr(`IQC_IDX_KEY_I_LO + g, k[8 * g +: 8]);
      wr(`IQC_IDX_SYNC, 8'h82);
      drive(k[15:0], k[31:16]);
      rd(`IQC_IDX_SYNC, d);
      chk_val(d & 32'h0000_0038, 32'h0000_0030);
      wr(`IQC_IDX_SYNC, 8'h81);
      sysref_req <= 1'h1;
      repeat (4) @(posedge aclk);
      sysref_req <= 1'h0;
      repeat (4) @(posedge aclk);
      rd(`IQC_IDX_SYNC, d);
      chk_val(d & 32'h0000_0038, 32'h0000_0010);
      chk_val(pulses, 2);
      for (g = 0; g < 2; g++) begin
         wr(`IQC_IDX_SYNC, g[0] ? 8'h83 : 8'h80);
         rd(`IQC_IDX_SYNC, d);
         chk_val(d & 32'h0000_0008, 32'h0000_0008);
      end
      $display("align test done");
      finish_test();
   end
endmodule : iqc_datapath_bench

bind iqc_datapath iqc_datapath_asserts chk (.*);
